// file: shared/strap_pkg.sv
// Constants, field positions and state codes for strap capture and start-up
package strap_pkg;

  // Pin and width defaults
  localparam int NUM_GPIO = 16;
  localparam int NUM_CLKOUT = 16;
  localparam int CFG_IDX_W = 4;
  localparam int CFG_WR_W = 16;

  // Fixed strap pins
  localparam int PIN_PORT_SEL = 9;
  localparam int PIN_HOLD_HIGH = 8;

  // Default configuration-select pins when none are assigned
  localparam logic [15:0] DEF_CFG_SEL_MASK = 16'h000F;

  // Configuration write addresses
  localparam logic [1:0] ADDR_PORT = 2'h0;
  localparam logic [1:0] ADDR_CLKOUT = 2'h1;
  localparam logic [1:0] ADDR_GPIO_OE = 2'h2;

  // Field positions inside the port word
  localparam int FLD_PORT_I2C = 0;
  localparam int FLD_ADDR_BIT2 = 1;

  // Reset values of the configuration registers
  localparam logic RST_PORT_I2C = 1'b1;
  localparam logic RST_ADDR_BIT2 = 1'b0;
  localparam logic [15:0] RST_CLKOUT = 16'h0000;
  localparam logic [15:0] RST_GPIO_OE = 16'h0000;

  // Start-up sequence, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CAPT = 9'h002,
    ST_OTP = 9'h004,
    ST_EEP = 9'h008,
    ST_REGS = 9'h010,
    ST_CLKS = 9'h020,
    ST_CAL = 9'h040,
    ST_LOCK = 9'h080,
    ST_DONE = 9'h100
  } seq_state_e;

endpackage : strap_pkg

// file: shared/strap_if.sv
// Captured strap pins, pin-function masks and decoded strap settings
`timescale 1ns/100ps
interface strap_if #(
  parameter int N = 16
);
  logic [N-1:0] pins;
  logic [N-1:0] addr_mask;
  logic [N-1:0] eep_mask;
  logic [N-1:0] sel_mask;
  logic info_valid;
  logic port_i2c;
  logic addr_bit2;
  logic eep_disable;
  logic [N-1:0] cfg_index;

  modport decoder (
    input pins,
    input addr_mask,
    input eep_mask,
    input sel_mask,
    input info_valid,
    output port_i2c,
    output addr_bit2,
    output eep_disable,
    output cfg_index
  );

  modport owner (
    output pins,
    output addr_mask,
    output eep_mask,
    output sel_mask,
    output info_valid,
    input port_i2c,
    input addr_bit2,
    input eep_disable,
    input cfg_index
  );
endinterface : strap_if

// file: rtl/strap_sync.sv
// Two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/100ps
module strap_sync #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  assign sync_o = sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      meta_d[i] = async_i[i];
      sync_d[i] = meta_q[i];
    end

    // Pins idle high through their pull-ups
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else if (clk_en) begin
        meta_q[i] <= meta_d[i];
        sync_q[i] <= sync_d[i];
      end
    end
  end

endmodule : strap_sync

// file: rtl/strap_decode.sv
// Maps captured pins through the function masks to strap settings
`timescale 1ns/100ps
module strap_decode #(
  parameter int N = 16
) (
  // Captured pins and decoded settings
  strap_if.decoder sif
);
  logic [N-1:0] am;
  logic [N-1:0] em;
  logic [N-1:0] sm;
  int k;

  always_comb begin
    // Unprogrammed record falls back to the default assignments
    am = sif.info_valid ? sif.addr_mask : '0;
    em = sif.info_valid ? sif.eep_mask : '0;
    sm = N'(strap_pkg::DEF_CFG_SEL_MASK);
    if (sif.info_valid && (|sif.sel_mask)) begin
      sm = sif.sel_mask;
    end
    sif.port_i2c = sif.pins[strap_pkg::PIN_PORT_SEL];
    sif.addr_bit2 = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (am[i]) begin
        sif.addr_bit2 = sif.pins[i];
      end
    end
    sif.eep_disable = |(sif.pins & em);
    sif.cfg_index = '0;
    k = 0;
    for (int i = 0; i < N; i++) begin
      if (sm[i]) begin
        sif.cfg_index[k] = sif.pins[i];
        k = k + 1;
      end
    end
  end

endmodule : strap_decode

// file: rtl/strap_config_loader.sv
// Strap capture at reset release and start-up configuration sequencing
// Function
// - Capture all pins when master reset rises; derive strap settings from them.
// - Pin 9 low selects SPI, high selects I2C for the main port.
// - Assigned address pin gives slave address bit 2; none assigned gives zero.
// - Address-bit strap only matters when the main port is I2C.
// - Several address pins assigned: only the highest-indexed one counts.
// - High on an EEPROM-disable pin skips all external EEPROM fetching.
// - No EEPROM-disable pin assigned: always search for an external EEPROM.
// - Several EEPROM-disable pins are ORed together.
// - No select pins assigned: pins 3 to 0 form the configuration index.
// - Pulled-up floating default select pins choose configuration 15.
// - Select pins ordered by index, lowest pin is the LSB.
// - Fewer than four select pins: upper index bits forced to zero.
// - More than four select pins form a wider selection word.
// - Pin functions come from the one-time info record, else defaults.
// - Port and address-bit strap settings are ordinary registers that later writes may overwrite.
// - Reset values keep clock outputs off and all pins as inputs.
// - Start-up order: load config, regulators, clocks, calibrate, lock PLL.
// - Config built from straps, stored config, EEPROM and reset defaults.
// - Stored configuration with bad checksum is not applied.
// - Index, up to 16 bits wide, chooses among the stored configurations.
`timescale 1ns/100ps
module strap_config_loader #(
  parameter int NGPIO = strap_pkg::NUM_GPIO,
  parameter int NCLKOUT = strap_pkg::NUM_CLKOUT
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Device pins
  input wire logic master_reset_n,
  input wire logic [NGPIO-1:0] gpio_pin,
  // Pin-function record from one-time memory
  input wire logic info_valid,
  input wire logic [NGPIO-1:0] addr_bit_mask,
  input wire logic [NGPIO-1:0] eep_dis_mask,
  input wire logic [NGPIO-1:0] cfg_sel_mask,
  // Start-up step handshakes
  input wire logic otp_done,
  input wire logic otp_checksum_ok,
  input wire logic eep_done,
  input wire logic regs_ok,
  input wire logic clks_ok,
  input wire logic cal_done,
  input wire logic pll_locked,
  // Configuration writes from stored data or host
  input wire logic cfg_wr_en,
  input wire logic [1:0] cfg_wr_addr,
  input wire logic [strap_pkg::CFG_WR_W-1:0] cfg_wr_data,
  // Strap results
  output logic port_i2c_q,
  output logic slave_addr_bit2_q,
  output logic eeprom_search_en_q,
  output logic [NGPIO-1:0] cfg_index_q,
  output logic strap_fault_q,
  // Sequence controls
  output logic otp_load_req_q,
  output logic otp_apply_q,
  output logic eep_search_req_q,
  output logic reg_enable_q,
  output logic clk_enable_q,
  output logic cal_start_q,
  output logic lock_start_q,
  output logic init_done_q,
  // Configuration registers
  output logic [NCLKOUT-1:0] clk_out_en_q,
  output logic [NGPIO-1:0] gpio_out_en_q
);

  strap_if #(.N(NGPIO)) sif ();

  logic [NGPIO:0] sync_out;
  logic mr_s;
  logic [NGPIO-1:0] gpio_s;
  logic mr_prev_q;
  logic mr_prev_d;
  logic rise;
  logic [NGPIO-1:0] cap_q;
  logic [NGPIO-1:0] cap_d;
  strap_pkg::seq_state_e state_q;
  strap_pkg::seq_state_e state_d;
  logic port_i2c_d;
  logic slave_addr_bit2_d;
  logic eeprom_search_en_d;
  logic [NGPIO-1:0] cfg_index_d;
  logic strap_fault_d;
  logic otp_apply_d;
  logic [NCLKOUT-1:0] clk_out_en_d;
  logic [NGPIO-1:0] gpio_out_en_d;
  logic wr_ok;

  // Reset line and pins share one delay so they stay aligned
  strap_sync #(.W(NGPIO + 1)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .async_i({master_reset_n, gpio_pin}),
    .sync_o(sync_out)
  );

  assign mr_s = sync_out[NGPIO];
  assign gpio_s = sync_out[NGPIO-1:0];
  assign rise = mr_s & ~mr_prev_q;

  assign sif.pins = cap_q;
  assign sif.addr_mask = addr_bit_mask;
  assign sif.eep_mask = eep_dis_mask;
  assign sif.sel_mask = cfg_sel_mask;
  assign sif.info_valid = info_valid;

  strap_decode #(.N(NGPIO)) u_decode (
    .sif(sif)
  );

  // Strap capture
  always_comb begin
    mr_prev_d = mr_s;
    cap_d = cap_q;
    if (rise) begin
      cap_d = gpio_s;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mr_prev_q <= 1'b1;
      cap_q <= '1;
    end else if (clk_en) begin
      mr_prev_q <= mr_prev_d;
      cap_q <= cap_d;
    end
  end

  // Start-up sequencer
  always_comb begin
    state_d = state_q;
    otp_apply_d = 1'b0;
    case (state_q)
      strap_pkg::ST_IDLE: begin
        if (rise) begin
          state_d = strap_pkg::ST_CAPT;
        end
      end
      strap_pkg::ST_CAPT: begin
        state_d = strap_pkg::ST_OTP;
      end
      strap_pkg::ST_OTP: begin
        if (otp_done) begin
          otp_apply_d = otp_checksum_ok;
          state_d = eeprom_search_en_q ? strap_pkg::ST_EEP
                                       : strap_pkg::ST_REGS;
        end
      end
      strap_pkg::ST_EEP: begin
        if (eep_done) begin
          state_d = strap_pkg::ST_REGS;
        end
      end
      strap_pkg::ST_REGS: begin
        if (regs_ok) begin
          state_d = strap_pkg::ST_CLKS;
        end
      end
      strap_pkg::ST_CLKS: begin
        if (clks_ok) begin
          state_d = strap_pkg::ST_CAL;
        end
      end
      strap_pkg::ST_CAL: begin
        if (cal_done) begin
          state_d = strap_pkg::ST_LOCK;
        end
      end
      strap_pkg::ST_LOCK: begin
        if (pll_locked) begin
          state_d = strap_pkg::ST_DONE;
        end
      end
      strap_pkg::ST_DONE: begin
        state_d = strap_pkg::ST_DONE;
      end
      default: begin
        state_d = strap_pkg::ST_IDLE;
      end
    endcase
    // Master reset held low restarts the whole sequence
    if (!mr_s) begin
      state_d = strap_pkg::ST_IDLE;
      otp_apply_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= strap_pkg::ST_IDLE;
      otp_load_req_q <= 1'b0;
      otp_apply_q <= 1'b0;
      eep_search_req_q <= 1'b0;
      reg_enable_q <= 1'b0;
      clk_enable_q <= 1'b0;
      cal_start_q <= 1'b0;
      lock_start_q <= 1'b0;
      init_done_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      otp_load_req_q <= (state_d == strap_pkg::ST_OTP);
      otp_apply_q <= otp_apply_d;
      eep_search_req_q <= (state_d == strap_pkg::ST_EEP);
      // Regulators and clocks stay on once brought up
      reg_enable_q <= (state_d inside {strap_pkg::ST_REGS,
          strap_pkg::ST_CLKS, strap_pkg::ST_CAL, strap_pkg::ST_LOCK,
          strap_pkg::ST_DONE});
      clk_enable_q <= (state_d inside {strap_pkg::ST_CLKS,
          strap_pkg::ST_CAL, strap_pkg::ST_LOCK, strap_pkg::ST_DONE});
      cal_start_q <= (state_d == strap_pkg::ST_CAL);
      lock_start_q <= (state_d == strap_pkg::ST_LOCK);
      init_done_q <= (state_d == strap_pkg::ST_DONE);
    end
  end

  // Strap results and configuration registers
  assign wr_ok = cfg_wr_en && mr_s &&
      !(state_q inside {strap_pkg::ST_IDLE, strap_pkg::ST_CAPT});

  always_comb begin
    port_i2c_d = port_i2c_q;
    slave_addr_bit2_d = slave_addr_bit2_q;
    eeprom_search_en_d = eeprom_search_en_q;
    cfg_index_d = cfg_index_q;
    strap_fault_d = strap_fault_q;
    clk_out_en_d = clk_out_en_q;
    gpio_out_en_d = gpio_out_en_q;
    if (!mr_s) begin
      port_i2c_d = strap_pkg::RST_PORT_I2C;
      slave_addr_bit2_d = strap_pkg::RST_ADDR_BIT2;
      clk_out_en_d = NCLKOUT'(strap_pkg::RST_CLKOUT);
      gpio_out_en_d = NGPIO'(strap_pkg::RST_GPIO_OE);
    end else if (state_q == strap_pkg::ST_CAPT) begin
      port_i2c_d = sif.port_i2c;
      slave_addr_bit2_d = sif.port_i2c & sif.addr_bit2;
      eeprom_search_en_d = ~sif.eep_disable;
      cfg_index_d = sif.cfg_index;
      // pin 8 must have been high
      strap_fault_d = ~cap_q[strap_pkg::PIN_HOLD_HIGH];
    end else if (wr_ok) begin
      if (cfg_wr_addr == strap_pkg::ADDR_PORT) begin
        port_i2c_d = cfg_wr_data[strap_pkg::FLD_PORT_I2C];
        slave_addr_bit2_d = cfg_wr_data[strap_pkg::FLD_ADDR_BIT2];
      end else if (cfg_wr_addr == strap_pkg::ADDR_CLKOUT) begin
        clk_out_en_d = cfg_wr_data[NCLKOUT-1:0];
      end else if (cfg_wr_addr == strap_pkg::ADDR_GPIO_OE) begin
        gpio_out_en_d = cfg_wr_data[NGPIO-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_i2c_q <= strap_pkg::RST_PORT_I2C;
      slave_addr_bit2_q <= strap_pkg::RST_ADDR_BIT2;
      eeprom_search_en_q <= 1'b1;
      cfg_index_q <= '0;
      strap_fault_q <= 1'b0;
      clk_out_en_q <= NCLKOUT'(strap_pkg::RST_CLKOUT);
      gpio_out_en_q <= NGPIO'(strap_pkg::RST_GPIO_OE);
    end else if (clk_en) begin
      port_i2c_q <= port_i2c_d;
      slave_addr_bit2_q <= slave_addr_bit2_d;
      eeprom_search_en_q <= eeprom_search_en_d;
      cfg_index_q <= cfg_index_d;
      strap_fault_q <= strap_fault_d;
      clk_out_en_q <= clk_out_en_d;
      gpio_out_en_q <= gpio_out_en_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_capture_on_rise: assert property (
    rise && clk_en |=> cap_q == $past(gpio_s)
  ) else $error("strap pins not captured at reset release");

  a_capture_hold: assert property (
    !(rise && clk_en) |=> $stable(cap_q)
  ) else $error("captured straps changed without reset release");

  a_port_select: assert property (
    state_q == strap_pkg::ST_CAPT && clk_en && mr_s
      |=> port_i2c_q == cap_q[strap_pkg::PIN_PORT_SEL]
  ) else $error("port protocol does not follow pin 9");

  a_addr_spi_zero: assert property (
    state_q == strap_pkg::ST_CAPT && clk_en && mr_s &&
      !cap_q[strap_pkg::PIN_PORT_SEL] |=> !slave_addr_bit2_q
  ) else $error("address strap applied to SPI port");

  a_default_index: assert property (
    state_q == strap_pkg::ST_CAPT && clk_en && mr_s && !info_valid
      |=> cfg_index_q == NGPIO'(cap_q[3:0])
  ) else $error("default index not taken from pins 3 to 0");

  a_eeprom_skip: assert property (
    state_q == strap_pkg::ST_OTP && otp_done && clk_en && mr_s &&
      !eeprom_search_en_q |=> state_q == strap_pkg::ST_REGS
  ) else $error("EEPROM searched although disabled");

  // Only a freshly launched pulse traces back to the previous edge
  a_checksum_bad: assert property (
    otp_apply_q && $past(clk_en) |-> $past(otp_checksum_ok) &&
      $past(otp_done)
  ) else $error("stored config applied with bad checksum");

  a_step_order: assert property (
    $rose(lock_start_q) |-> $past(cal_start_q) && clk_enable_q &&
      reg_enable_q
  ) else $error("PLL lock started out of order");

  a_reset_defaults: assert property (
    !mr_s && clk_en |=> clk_out_en_q == '0 && gpio_out_en_q == '0
  ) else $error("outputs or pin drivers on during reset");

  a_enable_freeze: assert property (
    !clk_en |=> $stable(state_q) && $stable(cap_q) && $stable(cfg_index_q)
  ) else $error("state moved while clock enable low");

  c_done: cover property (state_q == strap_pkg::ST_DONE);
  c_applied: cover property (otp_apply_q);
  c_eeprom: cover property (state_q == strap_pkg::ST_EEP);
  c_i2c_addr: cover property (port_i2c_q && slave_addr_bit2_q);

endmodule : strap_config_loader

// file: verification/strap_board.sv
// Board side model: strap resistors, driven pins and the master reset line
`timescale 1ns/100ps
module strap_board (
  // Bench commands
  input wire logic hold_reset,
  input wire logic [strap_pkg::NUM_GPIO-1:0] drive_val,
  input wire logic [strap_pkg::NUM_GPIO-1:0] drive_en,
  // Device pins
  output logic master_reset_n,
  output logic [strap_pkg::NUM_GPIO-1:0] gpio_pin
);
  always_comb begin
    gpio_pin = (drive_val & drive_en) | ~drive_en;
    // pin 8 held high through reset
    gpio_pin[strap_pkg::PIN_HOLD_HIGH] = 1'b1;
    master_reset_n = ~hold_reset;
  end
endmodule : strap_board

// file: verification/tb_strap_config_loader.sv
// Self-checking bench for strap capture and start-up sequencing
`timescale 1ns/100ps
module tb_strap_config_loader;
  typedef struct packed {
    logic i2c;
    logic a2;
    logic een;
    logic [15:0] idx;
  } strap_s;
  typedef struct packed {
    logic apply;
    logic eep;
    logic order;
  } seq_s;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic hold_reset = 1'b1;
  logic [15:0] drive_val = 16'h0000;
  logic [15:0] drive_en = 16'h0000;
  logic info_valid = 1'b0;
  logic [15:0] am = 16'h0000;
  logic [15:0] em = 16'h0000;
  logic [15:0] sm = 16'h0000;
  logic [5:0] dones = 6'h00;
  logic otp_ok = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] wr_addr = 2'h0;
  logic [15:0] wr_data = 16'h0000;
  logic master_reset_n, port_i2c_q, slave_addr_bit2_q, eeprom_search_en_q;
  logic strap_fault_q, otp_load_req_q, otp_apply_q, eep_search_req_q;
  logic reg_enable_q, clk_enable_q, cal_start_q, lock_start_q, init_done_q;
  logic [15:0] gpio_pin, cfg_index_q, clk_out_en_q, gpio_out_en_q;
  logic [31:0] seed = 32'h0000_d6d7;
  logic [31:0] r1, r2, r3;
  logic [4:0] lv, lv_prev;
  logic req_prev, apply_seen, eep_seen, order_bad;
  int stage;
  int fails = 0;
  int comparisons = 0;
  strap_s q_strap[$];
  seq_s q_seq[$];

  strap_board i_board (.hold_reset(hold_reset), .drive_val(drive_val),
    .drive_en(drive_en), .master_reset_n(master_reset_n),
    .gpio_pin(gpio_pin));

  strap_config_loader i_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .master_reset_n(master_reset_n), .gpio_pin(gpio_pin),
    .info_valid(info_valid), .addr_bit_mask(am), .eep_dis_mask(em),
    .cfg_sel_mask(sm), .otp_done(dones[0]), .otp_checksum_ok(otp_ok),
    .eep_done(dones[1]), .regs_ok(dones[2]), .clks_ok(dones[3]),
    .cal_done(dones[4]), .pll_locked(dones[5]), .cfg_wr_en(wr_en),
    .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data), .port_i2c_q(port_i2c_q),
    .slave_addr_bit2_q(slave_addr_bit2_q),
    .eeprom_search_en_q(eeprom_search_en_q), .cfg_index_q(cfg_index_q),
    .strap_fault_q(strap_fault_q), .otp_load_req_q(otp_load_req_q),
    .otp_apply_q(otp_apply_q), .eep_search_req_q(eep_search_req_q),
    .reg_enable_q(reg_enable_q), .clk_enable_q(clk_enable_q),
    .cal_start_q(cal_start_q), .lock_start_q(lock_start_q),
    .init_done_q(init_done_q), .clk_out_en_q(clk_out_en_q),
    .gpio_out_en_q(gpio_out_en_q));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < 32; i++) begin
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    end
    return r;
  endfunction : lfsr

  function automatic strap_s exp_strap(input logic [15:0] p,
      input logic inf, input logic [15:0] a, e, s);
    strap_s r;
    int k;
    logic [15:0] sel;
    r = '0;
    k = 0;
    sel = (inf && s != 16'h0000) ? s : strap_pkg::DEF_CFG_SEL_MASK;
    r.i2c = p[strap_pkg::PIN_PORT_SEL];
    r.een = !(inf && |(p & e));
    for (int i = 0; i < 16; i++) begin
      // Later pins overwrite, so the highest assigned pin wins
      if (inf && a[i] && r.i2c) r.a2 = p[i];
      if (sel[i]) begin
        r.idx[k] = p[i];
        k++;
      end
    end
    return r;
  endfunction : exp_strap

  task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_strap(input strap_s got, input strap_s exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_strap

  task automatic cmp_seq(input seq_s got, input seq_s exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_seq

  task automatic complete_run();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic trial(input logic inf, input logic [15:0] a, e, s, v, d,
      input logic ok);
    strap_s x;
    logic [15:0] p;
    p = (v & d) | ~d;
    p[strap_pkg::PIN_HOLD_HIGH] = 1'b1;
    x = exp_strap(p, inf, a, e, s);
    @(posedge clk_sys);
    hold_reset <= 1'b1;
    dones <= 6'h00;
    {info_valid, am, em, sm, drive_val, drive_en} <= {inf, a, e, s, v, d};
    otp_ok <= ok;
    repeat (5) @(posedge clk_sys);
    #1;
    cmp_val({port_i2c_q, slave_addr_bit2_q, clk_out_en_q, gpio_out_en_q},
      {2'b10, 32'h0000_0000});
    @(posedge clk_sys);
    hold_reset <= 1'b0;
    q_strap.push_back(x);
    q_seq.push_back(seq_s'{ok, x.een, 1'b1});
    for (int n = 0; n < 20 && otp_load_req_q !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    // Pin activity after capture must not leak into the settings
    drive_val <= ~v;
    drive_en <= 16'hffff;
    // Freeze for a few cycles while the pins move
    clk_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp_strap({port_i2c_q, slave_addr_bit2_q, eeprom_search_en_q,
      cfg_index_q}, x);
    cmp_val(48'(strap_fault_q), 48'h0);
    @(posedge clk_sys);
    dones <= 6'h3f;
    for (int n = 0; n < 40 && init_done_q !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
  endtask : trial

  // Result watcher: strap settings and start-up step order
  always @(posedge clk_sys) begin
    lv = {init_done_q, lock_start_q, cal_start_q, clk_enable_q, reg_enable_q};
    if (otp_load_req_q === 1'b1 && req_prev === 1'b0) begin
      if (q_strap.size() == 0) cmp_val(48'h1, 48'h0);
      else cmp_strap({port_i2c_q, slave_addr_bit2_q, eeprom_search_en_q,
        cfg_index_q}, q_strap.pop_front());
    end
    if (master_reset_n !== 1'b1) begin
      stage = 0;
      {apply_seen, eep_seen, order_bad} = 3'b000;
    end else begin
      apply_seen |= otp_apply_q;
      eep_seen |= eep_search_req_q;
      if ((lv & ~lv_prev) != 5'b0) begin
        if ((lv & ~lv_prev) != (5'b1 << stage)) order_bad = 1'b1;
        stage++;
      end
      if (lv[4] && !lv_prev[4] && q_seq.size() != 0) begin
        cmp_seq({apply_seen, eep_seen, !order_bad}, q_seq.pop_front());
      end
    end
    lv_prev = lv;
    req_prev = otp_load_req_q;
  end

  // Generous bound: eleven trials of under a hundred cycles each
  initial begin
    #100000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    cmp_val({port_i2c_q, eeprom_search_en_q, clk_out_en_q, gpio_out_en_q},
      {2'b11, 32'h0000_0000});
    trial(1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    seed = lfsr(seed);
    wr(2'h1, seed[15:0]);
    wr(2'h2, seed[31:16]);
    wr(2'h3, ~seed[15:0]);
    wr(2'h0, 16'h0002);
    @(posedge clk_sys);
    #1;
    cmp_val({port_i2c_q, slave_addr_bit2_q, clk_out_en_q, gpio_out_en_q},
      {2'b01, seed[15:0], seed[31:16]});
    trial(1'b0, 16'h0, 16'h0, 16'h0, 16'h0005, 16'h020f, 1'b0);
    trial(1'b1, 16'h00a0, 16'h0, 16'h0164, 16'h0220, 16'hffff, 1'b1);
    trial(1'b1, 16'h0001, 16'h0012, 16'h0c00, 16'h0811, 16'hffff,
      1'b1);
    trial(1'b1, 16'h0, 16'h0, 16'h03f0, 16'h02a0, 16'hffff, 1'b1);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      r1 = seed;
      seed = lfsr(seed);
      r2 = seed;
      seed = lfsr(seed);
      r3 = seed;
      trial(1'b1, r1[15:0], r1[31:16] & r2[15:0], r2[31:16], r3[15:0],
        r3[31:16], r3[0]);
    end
    cmp_val(48'(q_strap.size() + q_seq.size()), 48'h0);
    complete_run();
  end
endmodule : tb_strap_config_loader
